// >>> hdl/cmpev_pkg.sv
// constants and types for the comparator event logic
package cmpev_pkg;
  localparam int          CMPEV_AW        = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0]  CSR_IDX         = 8'h97;
  localparam logic [7:0]  IEN_IDX         = 8'h98;
  localparam logic [11:0] CSR_ADDR        = {2'b00, CSR_IDX, 2'b00};
  localparam logic [11:0] IEN_ADDR        = {2'b00, IEN_IDX, 2'b00};
  localparam logic [7:0]  CSR_RST         = 8'h00;
  localparam logic [7:0]  IEN_RST         = 8'h00;
  // field positions
  localparam int          IDLE_RUN_BIT    = 5;
  localparam int          EVT_FLAG_BIT    = 4;
  localparam int          ENABLE_BIT      = 3;
  localparam int          MODE_MSB        = 2;
  localparam int          IEN_CMP_BIT     = 6;
  // event modes
  localparam logic [2:0]  MODE_LOW        = 3'h0;
  localparam logic [2:0]  MODE_RISE       = 3'h1;
  localparam logic [2:0]  MODE_TOGGLE_DB  = 3'h2;
  localparam logic [2:0]  MODE_RISE_DB    = 3'h3;
  localparam logic [2:0]  MODE_FALL       = 3'h4;
  localparam logic [2:0]  MODE_TOGGLE     = 3'h5;
  localparam logic [2:0]  MODE_FALL_DB    = 3'h6;
  localparam logic [2:0]  MODE_HIGH       = 3'h7;

  typedef enum logic [1:0] {
    DB_IDLE  = 2'b00,
    DB_WAIT0 = 2'b01,
    DB_WAIT1 = 2'b11
  } cmpev_db_t;

  function automatic logic cmpev_is_db(input logic [2:0] m);
    cmpev_is_db = (m == MODE_TOGGLE_DB) || (m == MODE_RISE_DB) || (m == MODE_FALL_DB);
  endfunction
endpackage

// >>> hdl/cmpev_top.sv
// comparator event detection, debounce and control/status register
//
// Overview of operation
// - comparator input is one when positive exceeds negative
// - sample comparator output every clock cycle
// - debounced modes pace resampling on timer overflows
// - wait two timer overflows before resampling
// - matching resample sets flag, mismatch discards
// - debounced flag within one to two periods
// - idle-run bit keeps logic alive in idle
// - enabled flagged event wakes processor from idle when idle-run bit is set
// - power-down always shuts comparator logic down
// - flag set only when enabled; software clears
// - interrupt request only with enable bit six
// - enable low forces output low, no events
// - decode low, rise, fall, toggle, high modes
// - decode debounced toggle, rise, fall modes
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module cmpev_top
  import cmpev_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rstn_i,
  input  wire logic [CMPEV_AW-1:0] avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                cmp_raw_i,
  input  wire logic                tmr_ovf_i,
  input  wire logic                idle_mode_i,
  input  wire logic                powerdown_i,
  output logic                     cmp_out_o,
  output logic                     cmp_power_o,
  output logic                     cmp_irq_o,
  output logic                     wake_o
);

  logic            ack_r;
  logic [31:0]     rdata_r;
  logic            idle_run_r;
  logic            flag_r;
  logic            cmp_en_r;
  logic [2:0]      mode_r;
  logic            ien_cmp_r;
  logic            prev_r;
  logic            exp_r;
  cmpev_db_t       db_r;
  cmpev_db_t       db_nxt;

  logic            req;
  logic            wr_csr;
  logic            wr_ien;
  logic            active;
  logic            cmp_s;
  logic            rise;
  logic            fall;
  logic            lvl_hit;
  logic            db_start;
  logic            db_hit;
  logic            set_evt;

  // bus slave: one wait cycle, answer on the second edge
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o    = rdata_r;
  assign wr_csr = avs_write_i & ack_r & avs_byteenable_i[0] & (avs_address_i == CSR_ADDR);
  assign wr_ien = avs_write_i & ack_r & avs_byteenable_i[0] & (avs_address_i == IEN_ADDR);

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_r <= 32'h0000_0000;
    else if (avs_read_i && !ack_r)
    begin
      if (avs_address_i == CSR_ADDR)
        rdata_r <= {24'h00_0000, 2'b00, idle_run_r, flag_r, cmp_en_r, mode_r};
      else if (avs_address_i == IEN_ADDR)
        rdata_r <= {24'h00_0000, 1'b0, ien_cmp_r, 6'b00_0000};
      else
        rdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idle_run_r <= CSR_RST[IDLE_RUN_BIT];
      cmp_en_r   <= CSR_RST[ENABLE_BIT];
      mode_r     <= CSR_RST[MODE_MSB:0];
    end
    else if (wr_csr)
    begin
      idle_run_r <= avs_writedata_i[IDLE_RUN_BIT];
      cmp_en_r   <= avs_writedata_i[ENABLE_BIT];
      mode_r     <= avs_writedata_i[MODE_MSB:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ien_cmp_r <= IEN_RST[IEN_CMP_BIT];
    else if (wr_ien)
      ien_cmp_r <= avs_writedata_i[IEN_CMP_BIT];
  end

  // writing zero clears; a same-cycle event wins over the clear
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      flag_r <= CSR_RST[EVT_FLAG_BIT];
    else if (set_evt)
      flag_r <= 1'b1;
    else if (wr_csr && !avs_writedata_i[EVT_FLAG_BIT])
      flag_r <= 1'b0;
  end

  // power gating of the analog part and its logic
  assign active      = ~powerdown_i & (~idle_mode_i | idle_run_r);
  assign cmp_power_o = active;

  // raw input is high when positive input exceeds negative
  assign cmp_s = cmp_raw_i & cmp_en_r & active;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prev_r <= 1'b0;
    else
      prev_r <= cmp_s;
  end

  assign cmp_out_o = prev_r;
  assign rise      = cmp_s & ~prev_r;
  assign fall      = ~cmp_s & prev_r;

  always_comb
  begin
    unique case (mode_r)
      MODE_LOW:    lvl_hit = ~cmp_s;
      MODE_RISE:   lvl_hit = rise;
      MODE_FALL:   lvl_hit = fall;
      MODE_TOGGLE: lvl_hit = rise | fall;
      MODE_HIGH:   lvl_hit = cmp_s;
      default:     lvl_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    unique case (mode_r)
      MODE_TOGGLE_DB: db_start = rise | fall;
      MODE_RISE_DB:   db_start = rise;
      MODE_FALL_DB:   db_start = fall;
      default:        db_start = 1'b0;
    endcase
  end

  // the timer runs free, so two overflows bound the delay to 1..2 periods
  always_comb
  begin
    db_nxt = db_r;
    db_hit = 1'b0;
    if (!active || !cmp_en_r || !cmpev_is_db(mode_r))
      db_nxt = DB_IDLE;
    else
    begin
      unique case (db_r)
        DB_IDLE:
          if (db_start)
            db_nxt = DB_WAIT0;
        DB_WAIT0:
          if (tmr_ovf_i)
            db_nxt = DB_WAIT1;
        DB_WAIT1:
          if (tmr_ovf_i)
          begin
            db_nxt = DB_IDLE;
            db_hit = (cmp_s == exp_r);
          end
        default:
          db_nxt = DB_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      db_r <= DB_IDLE;
    else
      db_r <= db_nxt;
  end

  // expected level is whatever the input settled to right after the edge
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      exp_r <= 1'b0;
    else if (db_r == DB_IDLE && db_start)
      exp_r <= cmp_s;
  end

  assign set_evt = cmp_en_r & active & (lvl_hit | db_hit);

  assign cmp_irq_o = flag_r & ien_cmp_r;
  assign wake_o    = cmp_irq_o & idle_mode_i & idle_run_r & ~powerdown_i;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_gate;
    !cmp_en_r |=> !cmp_out_o;
  endproperty
  a_gate: assert property (p_gate) else $error("output not forced low");

  property p_hold;
    flag_r && !wr_csr |=> flag_r;
  endproperty
  a_hold: assert property (p_hold) else $error("flag cleared by hardware");

  property p_set_cause;
    $rose(flag_r) |-> $past(cmp_en_r) && $past(active);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("flag set while off");

  property p_irq_gate;
    !ien_cmp_r |-> !cmp_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_rise;
    mode_r == MODE_RISE && rise |=> flag_r;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_low;
    mode_r == MODE_LOW && cmp_en_r && active && !cmp_raw_i |=> flag_r;
  endproperty
  a_low: assert property (p_low) else $error("low level missed");

  // overflows seen since the wait was armed, counted apart from the state
  logic [1:0]      chk_ovf_r;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      chk_ovf_r <= 2'b00;
    else if (db_r == DB_IDLE)
      chk_ovf_r <= 2'b00;
    else if (tmr_ovf_i && chk_ovf_r != 2'b11)
      chk_ovf_r <= chk_ovf_r + 2'b01;
  end

  property p_db_two;
    db_r != DB_IDLE && chk_ovf_r == 2'b00 |-> !db_hit;
  endproperty
  a_db_two: assert property (p_db_two) else $error("resample too early");

  property p_db_hit;
    db_hit |-> tmr_ovf_i && chk_ovf_r == 2'b01;
  endproperty
  a_db_hit: assert property (p_db_hit) else $error("resample off overflow");

  property p_db_start;
    db_r == DB_IDLE && db_start && cmp_en_r && active |=> db_r == DB_WAIT0;
  endproperty
  a_db_start: assert property (p_db_start) else $error("debounce not armed");

  property p_exp;
    db_r == DB_IDLE && db_start |=> exp_r == $past(rise);
  endproperty
  a_exp: assert property (p_exp) else $error("wrong expected level");

  property p_miss;
    db_r == DB_WAIT1 && tmr_ovf_i && cmp_s != exp_r && !flag_r && !lvl_hit |=> !flag_r;
  endproperty
  a_miss: assert property (p_miss) else $error("mismatch set flag");

  property p_pd;
    powerdown_i |-> !cmp_power_o && !cmp_s;
  endproperty
  a_pd: assert property (p_pd) else $error("alive in power-down");

  property p_idle;
    idle_mode_i && !idle_run_r |-> !cmp_power_o;
  endproperty
  a_idle: assert property (p_idle) else $error("alive in idle");

  property p_wake;
    flag_r && ien_cmp_r && idle_mode_i && idle_run_r && !powerdown_i |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from idle");

  property p_bus;
    req && !ack_r |=> ack_r && !avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");

  c_db_set: cover property (db_hit && set_evt);
  c_db_drop: cover property (db_r == DB_WAIT1 && tmr_ovf_i && !db_hit);
  c_wake: cover property (wake_o);
  c_clear: cover property (flag_r ##1 !flag_r);

endmodule

// >>> tb/cmpev_far_model.sv
// far-side model: comparator level and free-running timer overflow
`timescale 1ns/100ps
module cmpev_far_model #(
  parameter int PERIOD = 10
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] pos_mv_i,
  input  wire logic [15:0] neg_mv_i,
  output logic             cmp_raw_o,
  output logic             tmr_ovf_o
);
  int cnt_r;

  assign cmp_raw_o = (pos_mv_i > neg_mv_i);
  // timer never stops, so an edge can land anywhere inside a period
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= 0;
    else
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
  end
  assign tmr_ovf_o = (cnt_r == PERIOD - 1);
endmodule

// >>> tb/cmpev_top_tb.sv
// self-checking bench for the comparator event block
`timescale 1ns/100ps
`define CHK(a, e) \
  begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module cmpev_top_tb;
  import cmpev_pkg::*;
  localparam int P = 10;
  logic        clk, rstn, rd_en, wr_en, idle, pdown, raw, ovf;
  logic        cmp_out, cmp_pwr, irq, wake, wreq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] pos_mv;
  logic [7:0]  q;
  int          errors, total_checks;

  cmpev_top uut (.core_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'h1), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .cmp_raw_i(raw), .tmr_ovf_i(ovf), .idle_mode_i(idle), .powerdown_i(pdown),
    .cmp_out_o(cmp_out), .cmp_power_o(cmp_pwr), .cmp_irq_o(irq), .wake_o(wake));
  cmpev_far_model #(.PERIOD(P)) far (.core_clk_i(clk), .rstn_i(rstn),
    .pos_mv_i(pos_mv), .neg_mv_i(16'h0100), .cmp_raw_o(raw), .tmr_ovf_o(ovf));

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // extra edge after release keeps back-to-back calls from double driving
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= {24'h00_0000, d};
    wr_en <= wr;
    rd_en <= !wr;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    q = rdata[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic lvl(input logic v);
    pos_mv <= v ? 16'h0180 : 16'h0080;
  endtask

  task automatic t_reset();
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q, CSR_RST)
    bus(0, IEN_ADDR, 8'h00);
    `CHK(q, IEN_RST)
    bus(1, 12'h0FC, 8'hFF);
    bus(0, 12'h0FC, 8'h00);
    `CHK(rdata, 32'h0000_0000)
    $display("test reset done");
  endtask

  task automatic t_modes();
    logic [2:0] md [5] = '{MODE_LOW, MODE_RISE, MODE_FALL, MODE_TOGGLE, MODE_HIGH};
    foreach (md[i])
    begin
      bus(1, CSR_ADDR, {5'h01, md[i]});
      bus(1, CSR_ADDR, {5'h01, md[i]});
      bus(0, CSR_ADDR, 8'h00);
      `CHK(q[EVT_FLAG_BIT], md[i] == MODE_LOW)
      lvl(1);
      cyc(3);
      `CHK(cmp_out, 1'b1)
      bus(0, CSR_ADDR, 8'h00);
      `CHK(q[EVT_FLAG_BIT], md[i] != MODE_FALL)
      bus(1, CSR_ADDR, {5'h01, md[i]});
      lvl(0);
      cyc(3);
      bus(0, CSR_ADDR, 8'h00);
      `CHK(q[EVT_FLAG_BIT], md[i] != MODE_RISE)
    end
    $display("test modes done");
  endtask

  task automatic t_enirq();
    bus(1, CSR_ADDR, {5'h00, MODE_RISE});
    lvl(1);
    cyc(3);
    `CHK(cmp_out, 1'b0)
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q, {5'h00, MODE_RISE})
    lvl(0);
    bus(1, CSR_ADDR, {5'h01, MODE_RISE});
    lvl(1);
    cyc(3);
    `CHK(irq, 1'b0)
    bus(1, IEN_ADDR, 8'h40);
    `CHK(irq, 1'b1)
    bus(1, CSR_ADDR, {5'h01, MODE_RISE});
    `CHK(irq, 1'b0)
    $display("test enable_irq done");
  endtask

  // e low: level falls back one cycle later, so the resample disagrees
  task automatic t_db(input logic [2:0] m, input logic a, input logic b, input logic e);
    bus(1, CSR_ADDR, 8'h00);
    lvl(a);
    bus(1, CSR_ADDR, {5'h01, m});
    lvl(b);
    cyc(1);
    lvl(e ? b : a);
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q[EVT_FLAG_BIT], 1'b0)
    // read captures the flag on the edge of the earliest second overflow, before it sets
    cyc(P - 3);
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q[EVT_FLAG_BIT], 1'b0)
    // read captures the flag just after the latest possible second overflow
    cyc(P - 3);
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q[EVT_FLAG_BIT], e)
    $display("test debounce mode %0d done", m);
  endtask

  task automatic t_power();
    lvl(0);
    bus(1, CSR_ADDR, {5'h01, MODE_RISE});
    idle <= 1'b1;
    cyc(2);
    `CHK(cmp_pwr, 1'b0)
    lvl(1);
    cyc(3);
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q[EVT_FLAG_BIT], 1'b0)
    lvl(0);
    bus(1, CSR_ADDR, {5'h05, MODE_RISE});
    `CHK(cmp_pwr, 1'b1)
    lvl(1);
    cyc(3);
    `CHK(wake, 1'b1)
    pdown <= 1'b1;
    bus(1, CSR_ADDR, {5'h05, MODE_RISE});
    `CHK(cmp_pwr, 1'b0)
    lvl(0);
    cyc(2);
    lvl(1);
    cyc(3);
    bus(0, CSR_ADDR, 8'h00);
    `CHK(q[EVT_FLAG_BIT], 1'b0)
    idle  <= 1'b0;
    pdown <= 1'b0;
    $display("test power done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    final_report();
  end

  initial
  begin
    {rstn, rd_en, wr_en, idle, pdown} = 5'h00;
    addr   = 12'h000;
    wdata  = 32'h0000_0000;
    pos_mv = 16'h0080;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_modes();
    t_enirq();
    bus(1, IEN_ADDR, 8'h40);
    t_db(MODE_RISE_DB, 1'b0, 1'b1, 1'b1);
    t_db(MODE_FALL_DB, 1'b1, 1'b0, 1'b1);
    t_db(MODE_TOGGLE_DB, 1'b0, 1'b1, 1'b1);
    t_db(MODE_RISE_DB, 1'b0, 1'b1, 1'b0);
    t_db(MODE_TOGGLE_DB, 1'b0, 1'b1, 1'b0);
    t_power();
    final_report();
  end
endmodule
